/* verilog/tcl_led.sv */
// Two-colour indicator pattern generator with an AXI4-Lite register slave.
// Assumes one 250 MHz clock, synchronous active-low reset, one master.
// Notes on behaviour
// RL1: internal firmware mode or script command mode
// RL2: deactivated indicator ignores all commands
// RL3: on lights flagged colours, others unchanged
// RL4: red and green may light together
// RL5: off darkens flagged colours, others unchanged
// RL6: blink is 500 ms lit, 500 ms dark
// RL7: count -1 dark, 0 forever, n times
// RL8: brief flash pulse every 500 ms
// RL9: positive flash count gives exactly n pulses
// RL10: flicker is 94 ms lit, 31 ms dark
// RL11: flicker count zero runs until off
// RL12: green and red counts are independent
// RL13: bad parameters rejected, error, state kept
// RL14: brief flash lit time fixed 31 ms
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "tcl_params.svh"
module tcl_led
  import tcl_pkg::*;
#(
  parameter int MS_CYCLES = `TCL_MS_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fw_red,
  input wire logic fw_green,
  output logic led_red,
  output logic led_green
);
  // Write channel capture
  logic aw_ff, nxt_aw;
  logic w_ff, nxt_w;
  logic [11:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic err_ff, nxt_err;
  logic [31:0] tick_ff, nxt_tick;
  logic ms_tick;
  tcl_cmd_t red_cmd, grn_cmd;
  logic red_pat, grn_pat;
  logic wr_go;
  logic [31:0] cmd_word;
  tcl_op_t op;
  logic [7:0] red_cnt, grn_cnt;
  logic cmd_ok;
  logic is_count_op;

  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_go = aw_ff && w_ff && !bvalid_ff;

  // Command decode; counts are signed bytes, below -1 is illegal
  always_comb
  begin
    cmd_word = wdata_ff;
    op = tcl_op_t'(cmd_word[`TCL_CMD_OP_LSB +: 3]);
    red_cnt = cmd_word[`TCL_CMD_RED_LSB +: 8];
    grn_cnt = cmd_word[`TCL_CMD_GRN_LSB +: 8];
    is_count_op = (op == TCL_OP_BLINK) || (op == TCL_OP_FLASH) || (op == TCL_OP_FLICK);
    cmd_ok = (op == TCL_OP_ON) || (op == TCL_OP_OFF) || is_count_op;
    if (!is_count_op && (cmd_word[31:3] & ~29'h0000_2020) != 29'h0)
      cmd_ok = 1'b0; // [RL13]
    if (is_count_op && (cmd_word[31:24] != 8'h00 || cmd_word[7:3] != 5'h00))
      cmd_ok = 1'b0; // [RL13]
    if (is_count_op && ((red_cnt[7] && red_cnt != 8'hff) || (grn_cnt[7] && grn_cnt != 8'hff)))
      cmd_ok = 1'b0; // [RL13]
  end

  // Bus slave and register next values
  always_comb
  begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_ctrl = ctrl_ff;
    nxt_err = err_ff;
    red_cmd = '0;
    grn_cmd = '0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (wr_go)
    begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = 2'b00;
      if (awaddr_ff[11:2] == `TCL_REG_CTRL >> 2)
      begin
        if (wstrb_ff[0])
          nxt_ctrl = wdata_ff[1:0]; // [RL1]
      end
      else if (awaddr_ff[11:2] == `TCL_REG_CMD >> 2)
      begin
        // Commands need all lanes; partial writes are refused
        if (!ctrl_ff[`TCL_CTRL_ENABLE] || !ctrl_ff[`TCL_CTRL_SCRIPT])
          nxt_bresp = 2'b00; // [RL2]
        else if (!cmd_ok || wstrb_ff != 4'hf)
        begin
          nxt_err = 1'b1; // [RL13]
          nxt_bresp = 2'b10; // [RL13]
        end
        else
        begin
          nxt_err = 1'b0;
          // Each colour gets its own command and count
          red_cmd.op = op;
          grn_cmd.op = op;
          red_cmd.count = red_cnt; // [RL12]
          grn_cmd.count = grn_cnt; // [RL12]
          red_cmd.valid = is_count_op || cmd_word[`TCL_CMD_ON_RED]; // [RL3] [RL5]
          grn_cmd.valid = is_count_op || cmd_word[`TCL_CMD_ON_GRN]; // [RL3] [RL5]
        end
      end
      else if (awaddr_ff[11:2] != `TCL_REG_STATUS >> 2 && awaddr_ff[11:2] != `TCL_REG_LED >> 2)
        nxt_bresp = 2'b11;
    end
    if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = 2'b00;
      nxt_rdata = 32'h0000_0000;
      if (s_axi_araddr[11:2] == `TCL_REG_CTRL >> 2)
        nxt_rdata = {30'h0, ctrl_ff};
      else if (s_axi_araddr[11:2] == `TCL_REG_CMD >> 2)
        nxt_rdata = 32'h0000_0000;
      else if (s_axi_araddr[11:2] == `TCL_REG_STATUS >> 2)
        nxt_rdata = {29'h0, led_green, led_red, err_ff};
      else if (s_axi_araddr[11:2] == `TCL_REG_LED >> 2)
        nxt_rdata = {30'h0, grn_pat, red_pat};
      else
        nxt_rresp = 2'b11;
    end
    else if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
  end

  // Millisecond divider
  always_comb
  begin
    nxt_tick = (tick_ff >= 32'(MS_CYCLES - 1)) ? 32'h0 : tick_ff + 32'h1;
  end
  assign ms_tick = (tick_ff >= 32'(MS_CYCLES - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= 2'b00;
      ctrl_ff <= 2'(`TCL_CTRL_RESET);
      err_ff <= 1'b0;
      tick_ff <= 32'h0;
    end
    else
    begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      ctrl_ff <= nxt_ctrl;
      err_ff <= nxt_err;
      tick_ff <= nxt_tick;
    end
  end

  // Per-colour engines run independently
  tcl_colour u_red
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .ms_tick(ms_tick),
    .cmd(red_cmd),
    .led(red_pat)
  );
  tcl_colour u_grn
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .ms_tick(ms_tick),
    .cmd(grn_cmd),
    .led(grn_pat)
  );

  // Output select; both may be lit for orange, off while deactivated
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_red <= 1'b0;
      led_green <= 1'b0;
    end
    else if (!ctrl_ff[`TCL_CTRL_ENABLE])
    begin
      led_red <= 1'b0; // [RL2]
      led_green <= 1'b0; // [RL2]
    end
    else
    begin
      led_red <= ctrl_ff[`TCL_CTRL_SCRIPT] ? red_pat : fw_red; // [RL1] [RL4]
      led_green <= ctrl_ff[`TCL_CTRL_SCRIPT] ? grn_pat : fw_green; // [RL1] [RL4]
    end
  end
endmodule // tcl_led

/* verilog/tcl_params.svh */
// Constants for the two-colour indicator pattern block: register offsets,
// field positions, reset values and millisecond timing.
// Assumes a 250 MHz aclk; all counts are derived from the printed times.
`ifndef TCL_PARAMS_SVH
`define TCL_PARAMS_SVH

`define TCL_CLK_HZ 250000000
`define TCL_MS_CYCLES (`TCL_CLK_HZ / 1000)

// Pattern times in milliseconds
`define TCL_BLINK_ON_MS 500
`define TCL_BLINK_OFF_MS 500
`define TCL_FLASH_PERIOD_MS 500
`define TCL_FLASH_ON_MS 31
`define TCL_FLICK_ON_MS 94
`define TCL_FLICK_OFF_MS 31

// Register byte offsets
`define TCL_REG_CTRL 12'h000
`define TCL_REG_CMD 12'h004
`define TCL_REG_STATUS 12'h008
`define TCL_REG_LED 12'h00c

// CTRL fields
`define TCL_CTRL_ENABLE 0
`define TCL_CTRL_SCRIPT 1
`define TCL_CTRL_RESET 32'h0000_0000

// CMD fields: opcode [2:0], red count [15:8], green count [23:16]
`define TCL_CMD_OP_LSB 0
`define TCL_CMD_RED_LSB 8
`define TCL_CMD_GRN_LSB 16
`define TCL_CMD_ON_RED 8
`define TCL_CMD_ON_GRN 16

// STATUS fields
`define TCL_STAT_ERR 0
`define TCL_STAT_RED 1
`define TCL_STAT_GRN 2

`endif

/* verilog/tcl_pkg.sv */
// Types shared by the indicator pattern block and its per-colour engine.
package tcl_pkg;
  typedef enum logic [2:0]
  {
    TCL_OP_NONE = 3'h0,
    TCL_OP_ON = 3'h1,
    TCL_OP_OFF = 3'h2,
    TCL_OP_BLINK = 3'h3,
    TCL_OP_FLASH = 3'h4,
    TCL_OP_FLICK = 3'h5
  } tcl_op_t;

  typedef enum logic [3:0]
  {
    TCL_ST_DARK = 4'b0001,
    TCL_ST_STEADY = 4'b0010,
    TCL_ST_LIT = 4'b0100,
    TCL_ST_GAP = 4'b1000
  } tcl_state_t;

  // One command to a single colour engine
  typedef struct packed
  {
    logic valid;
    tcl_op_t op;
    logic [7:0] count;
  } tcl_cmd_t;
endpackage

/* verilog/tcl_colour.sv */
// One colour engine: steady on/off, blink, brief flash and flicker.
// Assumes a one-cycle millisecond tick and commands already checked.
`timescale 1ns/100ps
`include "tcl_params.svh"
module tcl_colour
  import tcl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ms_tick,
  input tcl_cmd_t cmd,
  output logic led
);
  tcl_state_t state_ff, nxt_state;
  tcl_op_t mode_ff, nxt_mode;
  logic [9:0] ms_ff, nxt_ms;
  logic [7:0] left_ff, nxt_left;
  logic forever_ff, nxt_forever;

  // Lit and dark lengths for the running pattern
  logic [9:0] on_ms, off_ms;
  always_comb
  begin
    on_ms = 10'(`TCL_BLINK_ON_MS);
    off_ms = 10'(`TCL_BLINK_OFF_MS);
    if (mode_ff == TCL_OP_FLASH)
    begin
      on_ms = 10'(`TCL_FLASH_ON_MS); // [RL14]
      off_ms = 10'(`TCL_FLASH_PERIOD_MS - `TCL_FLASH_ON_MS); // [RL8]
    end
    else if (mode_ff == TCL_OP_FLICK)
    begin
      on_ms = 10'(`TCL_FLICK_ON_MS); // [RL10]
      off_ms = 10'(`TCL_FLICK_OFF_MS); // [RL10]
    end
  end

  // Next state; a new pattern command restarts from its lit phase unless its count is -1, which goes dark
  always_comb
  begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_ms = ms_ff;
    nxt_left = left_ff;
    nxt_forever = forever_ff;
    if (cmd.valid)
    begin
      nxt_ms = 10'h000;
      nxt_mode = cmd.op;
      case (cmd.op)
        TCL_OP_ON: nxt_state = TCL_ST_STEADY; // [RL3]
        TCL_OP_OFF: nxt_state = TCL_ST_DARK; // [RL5]
        default:
        begin
          nxt_forever = (cmd.count == 8'h00); // [RL7] [RL11]
          nxt_left = cmd.count;
          nxt_state = (cmd.count == 8'hff) ? TCL_ST_DARK : TCL_ST_LIT; // [RL7] [RL12]
        end
      endcase
    end
    else if (ms_tick)
    begin
      case (state_ff)
        TCL_ST_LIT:
        begin
          nxt_ms = ms_ff + 10'h001;
          if (ms_ff + 10'h001 >= on_ms)
          begin
            nxt_ms = 10'h000;
            nxt_state = TCL_ST_GAP; // [RL6]
          end
        end
        TCL_ST_GAP:
        begin
          nxt_ms = ms_ff + 10'h001;
          if (ms_ff + 10'h001 >= off_ms)
          begin
            nxt_ms = 10'h000;
            if (forever_ff)
              nxt_state = TCL_ST_LIT;
            else if (left_ff > 8'h01)
            begin
              nxt_left = left_ff - 8'h01;
              nxt_state = TCL_ST_LIT;
            end
            else
              nxt_state = TCL_ST_DARK; // [RL9]
          end
        end
        default: nxt_state = state_ff;
      endcase
    end
  end

  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= TCL_ST_DARK;
      mode_ff <= TCL_OP_NONE;
      ms_ff <= 10'h000;
      left_ff <= 8'h00;
      forever_ff <= 1'b0;
      led <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      ms_ff <= nxt_ms;
      left_ff <= nxt_left;
      forever_ff <= nxt_forever;
      led <= (nxt_state == TCL_ST_STEADY) || (nxt_state == TCL_ST_LIT);
    end
  end
endmodule // tcl_colour

/* test/tcl_led_mon.sv */
// LED watcher: counts rises, times last lit and dark runs.
// Assumes an active-high drive level.
`timescale 1ns/100ps
module tcl_led_mon (
  input wire logic aclk,
  input wire logic clr,
  input wire logic led,
  output int rises,
  output int on_len,
  output int off_len
);
  int run = 0;
  logic prev = 1'b0;
  // Run length taken at each change of level
  always @(posedge aclk)
  begin
    prev <= led;
    run <= (led !== prev) ? 1 : run + 1;
    if (clr)
    begin
      rises <= 0;
      on_len <= 0;
    end
    else if (led && !prev)
    begin
      rises <= rises + 1;
      off_len <= run;
    end
    else if (!led && prev)
      on_len <= run;
  end
endmodule // tcl_led_mon

/* test/tcl_led_assertions.sv */
// Checker on the indicator block ports.
// Assumes the master offers address and data together.
`timescale 1ns/100ps
module tcl_led_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic led_red,
  input wire logic led_green
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic dis;
  // Shadow of the control word; split address and data would be missed
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 12'h000)
      nxt_ctrl = s_axi_wdata[1:0];
  end
  always_ff @(posedge aclk)
    ctrl_ff <= aresetn ? nxt_ctrl : 2'h0;
  assign dis = !ctrl_ff[0];
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped early");
  bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  decerr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b11 |-> s_axi_rdata == 32'h0)
    else $error("decode error with data");
  dark_when_off_a: assert property (dis && $past(dis, 3) |-> !led_red && !led_green)
    else $error("led lit while deactivated");
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b11);
  cover property (led_red && led_green);
endmodule // tcl_led_assertions

/* test/tb.sv */
// Bench for the indicator block: AXI4-Lite master tasks, LED watchers.
// Assumes MS_CYCLES of 4, so one millisecond is four clocks.
`timescale 1ns/100ps
module tb;
  localparam int MS = 4;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, led_red, led_green;
  logic fw_red = 0, fw_green = 0, clr = 0;
  logic [3:0] wstrb = 4'hf;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [31:0] bad [4];
  logic [1:0] bresp, rresp;
  int err_total = 0, n_compared = 0, n, rr, rg, on_r, off_r, on_g, off_g;
  tcl_led #(.MS_CYCLES(MS)) i_tcl_led (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fw_red, .fw_green, .led_red, .led_green);
  tcl_led_mon u_mon_r (.aclk, .clr, .led(led_red), .rises(rr), .on_len(on_r), .off_len(off_r));
  tcl_led_mon u_mon_g (.aclk, .clr, .led(led_green), .rises(rg), .on_len(on_g), .off_len(off_g));
  always #2 aclk = ~aclk;
  function automatic logic [31:0] stat(input logic e, input logic r, input logic g);
    return {29'h0, g, r, e};
  endfunction
  function automatic logic [31:0] pat(input logic [2:0] op, input logic [7:0] rc, input logic [7:0] gc);
    return {8'h0, gc, rc, 5'h0, op};
  endfunction
  function automatic int cyc(input int ms);
    return ms * MS;
  endfunction
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    n_compared++;
    if (a !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, a, e);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, e});
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  // Three clocks cover the command-to-LED latency
  task automatic leds(input logic er, input logic eg);
    repeat (3) @(posedge aclk);
    chk({30'h0, led_green, led_red}, {30'h0, eg, er});
  endtask
  task automatic clear;
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well past the longest pattern run
  initial
  begin
    repeat (40000) @(posedge aclk);
    err_total++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'h1a4d));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h000, 0, 2'b00);
    rd(12'h008, 0, 2'b00);
    rd(12'h010, 0, 2'b11);
    wr(12'h010, 32'h0, 2'b11);
    wr(12'h004, 32'h0001_0101, 2'b00);
    leds(0, 0);
    wr(12'h000, 32'h1, 2'b00);
    for (int i = 0; i < 4; i++)
    begin
      fw_red <= 1'($urandom);
      fw_green <= 1'($urandom);
      @(posedge aclk);
      leds(fw_red, fw_green);
    end
    fw_red <= 1'b1;
    fw_green <= 1'b1;
    wr(12'h000, 32'h0, 2'b00);
    leds(0, 0);
    $display("modes done");
    wr(12'h000, 32'h3, 2'b00);
    // Earlier on command was ignored and firmware levels no longer count
    leds(0, 0);
    wr(12'h004, 32'h0000_0101, 2'b00);
    leds(1, 0);
    wr(12'h004, 32'h0001_0001, 2'b00);
    leds(1, 1);
    wr(12'h004, 32'h0000_0102, 2'b00);
    leds(0, 1);
    rd(12'h00c, 32'h0000_0002, 2'b00);
    // Last one would be a valid green off if the top byte were ignored
    bad = '{32'h0000_0006, 32'h0000_0109, 32'h0080_0003, {8'($urandom_range(255, 1)), 24'h010002}};
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h004, bad[i], 2'b10);
      rd(12'h008, stat(1, 0, 1), 2'b00);
    end
    // Partial lane write of a legal red on must be refused
    wstrb <= 4'h7;
    wr(12'h004, 32'h0000_0101, 2'b10);
    wstrb <= 4'hf;
    rd(12'h008, stat(1, 0, 1), 2'b00);
    wr(12'h004, 32'h0001_0002, 2'b00);
    rd(12'h008, stat(0, 0, 0), 2'b00);
    $display("on off done");
    clear();
    wr(12'h004, pat(3'h3, 8'h02, 8'hff), 2'b00);
    repeat (cyc(2000) + 100) @(posedge aclk);
    chk(rr, 2);
    chk(on_r, cyc(500));
    chk(off_r, cyc(500));
    chk(rg, 0);
    n = 2 + $urandom_range(1);
    clear();
    wr(12'h004, pat(3'h4, 8'hff, 8'(n)), 2'b00);
    repeat (cyc(500) * n + 100) @(posedge aclk);
    chk(rg, n);
    chk(on_g, cyc(31));
    chk(off_g, cyc(500 - 31));
    chk(rr, 0);
    $display("blink flash done");
    clear();
    wr(12'h004, pat(3'h5, 8'h00, 8'h00), 2'b00);
    repeat (cyc(125) * 8) @(posedge aclk);
    chk(on_r, cyc(94));
    chk(off_g, cyc(31));
    wr(12'h004, 32'h0000_0102, 2'b00);
    clear();
    repeat (cyc(125) * 3) @(posedge aclk);
    chk(rr, 0);
    chk(on_g, cyc(94));
    $display("flicker done");
    print_verdict();
  end
endmodule // tb
bind tcl_led tcl_led_assertions u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .led_red, .led_green);
